// File: tb/mms_board.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------------
// Board strap model
// ---------------------------------------------------------------------
module mms_board (
   input wire logic rst_n,
   output logic [2:0] strap_pins
);
   logic [2:0] code_reg = 3'h1;

   assign strap_pins = code_reg;

   // A new code is taken only while the device sits in reset, because the
   // straps must never move under a running device.
   task automatic load(input logic [2:0] code);
      if (rst_n === 1'b0) begin
         code_reg = code;
      end
   endtask
endmodule // mms_board

// File: tb/mms_mode_map_tb.sv
`timescale 1ns/10ps
module mms_mode_map_tb;
   import mms_pkg::*;
   logic REF_CLK = 1'b0;
   logic RSTN = 1'b0;
   logic [2:0] STRAP_PINS;
   logic [3:0] ACC_PAGE = 4'h0;
   logic [15:0] ACC_ADDR = 16'h0;
   logic ACC_VALID = 1'b0;
   logic ACC_FETCH = 1'b0;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [15:0] REG_ADDR = 16'h0;
   logic [7:0] REG_WDATA = 8'h0;
   logic [7:0] REG_RDATA;
   logic [2:0] LATCHED_STRAP_BITS;
   logic [3:0] PAGE_LAST, ACC_TARGET;
   logic MAX_MODE, ROM_MAPPED, VECTORS_IN_ROM, EXT_BUS_EN, PORT6_ADDR_EN;
   logic PORT5_INIT_INPUT, PORT6_INIT_INPUT, SAVE_CODE_PAGE, RAM_ENABLE;
   logic ADDR_ERROR, FETCH_ERROR;
   int mismatches = 0;
   int samples_checked = 0;
   logic [15:0] corner [8] = '{16'hfe7f, 16'hfe80, 16'hf680, 16'hf67f,
      16'h7fff, 16'h8000, 16'hffff, 16'h0000};
   logic [2:0] codes [6] = '{MODE_1, MODE_2, MODE_3, MODE_4, MODE_7, 3'h5};

   mms_board i_mms_board (.rst_n(RSTN), .strap_pins(STRAP_PINS));
   mms_mode_map i_mms_mode_map (.REF_CLK, .RSTN, .STRAP_PINS, .ACC_PAGE,
      .ACC_ADDR, .ACC_VALID, .ACC_FETCH, .REG_WR, .REG_RD, .REG_ADDR,
      .REG_WDATA, .REG_RDATA, .LATCHED_STRAP_BITS, .MAX_MODE, .ROM_MAPPED,
      .VECTORS_IN_ROM, .EXT_BUS_EN, .PORT6_ADDR_EN, .PORT5_INIT_INPUT,
      .PORT6_INIT_INPUT, .SAVE_CODE_PAGE, .PAGE_LAST, .RAM_ENABLE,
      .ACC_TARGET, .ADDR_ERROR, .FETCH_ERROR);

   always #12.5 REF_CLK = ~REF_CLK;

   // ------------------------------------------------------------------
   // Expectations
   // ------------------------------------------------------------------
   function automatic logic [11:0] exp_flags(input logic [2:0] m);
      logic mx, rm, vr, eb;
      mx = (m == MODE_3) || (m == MODE_4);
      rm = (m == MODE_2) || (m == MODE_4) || (m == MODE_7);
      vr = (m == MODE_2) || (m == MODE_4);
      eb = (m >= MODE_1) && (m <= MODE_4);
      return {mx, rm, vr, eb, mx, vr, m == MODE_4, mx, {4{mx}}};
   endfunction

   function automatic logic [4:0] exp_acc(input logic [2:0] m,
      input logic ram, input logic [3:0] pg, input logic [15:0] a);
      logic [11:0] f;
      logic [3:0] t;
      f = exp_flags(m);
      if (pg != 4'h0) t = MMS_TGT_EXT;
      else if (a >= REG_FIELD_BASE) t = MMS_TGT_REG;
      else if (ram && a >= RAM_BASE && a <= RAM_LAST) t = MMS_TGT_RAM;
      else if (f[10] && a <= ROM_LAST_DEFAULT) t = MMS_TGT_ROM;
      else t = MMS_TGT_EXT;
      // Off-chip targets are refused where no bus or no page exists.
      if (t == MMS_TGT_EXT && (m == MODE_7 || (pg != 4'h0 && !f[11])))
         return 5'h10;
      return {1'b0, t};
   endfunction

   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge REF_CLK);
      REG_WR = 1'b1;
      REG_ADDR = a;
      REG_WDATA = d;
      @(negedge REF_CLK);
      REG_WR = 1'b0;
   endtask

   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge REF_CLK);
      REG_RD = 1'b1;
      REG_ADDR = a;
      @(negedge REF_CLK);
      REG_RD = 1'b0;
      d = REG_RDATA;
   endtask

   // ------------------------------------------------------------------
   // One reset per strap code, then registers and, for every code but 5, a stream of accesses
   // ------------------------------------------------------------------
   task automatic run_mode(input logic [2:0] m);
      logic [7:0] d;
      logic [4:0] pe;
      logic [3:0] pg;
      logic [15:0] a;
      logic f, pf;
      @(negedge REF_CLK);
      RSTN = 1'b0;
      // The board only takes a code once it sees reset on its own pin.
      @(negedge REF_CLK);
      i_mms_board.load(m);
      repeat (3) @(negedge REF_CLK);
      RSTN = 1'b1;
      repeat (10) @(negedge REF_CLK);
      chk("flags", {MAX_MODE, ROM_MAPPED, VECTORS_IN_ROM, EXT_BUS_EN,
         PORT6_ADDR_EN, PORT5_INIT_INPUT, PORT6_INIT_INPUT,
         SAVE_CODE_PAGE, PAGE_LAST},
         exp_flags(m));
      chk("straps", LATCHED_STRAP_BITS, m);
      reg_rd(MODE_STATUS_ADDR, d);
      chk("mode_status", d, {MODE_STATUS_FIXED, m});
      reg_wr(MODE_STATUS_ADDR, 8'($urandom));
      reg_rd(MODE_STATUS_ADDR, d);
      chk("mode_status_wr", d, {MODE_STATUS_FIXED, m});
      if (exp_flags(m) == 12'h000) return;
      reg_rd(16'h1234, d);
      chk("unmapped", d, 8'h00);
      for (int r = 0; r < 2; r++) begin
         reg_rd(RAM_CONTROL_ADDR, d);
         chk("ram_control", d, r == 0 ? RAM_CONTROL_RESET : 8'h00);
         chk("ram_enable", RAM_ENABLE, r == 0);
         pe = 5'h00;
         pf = 1'b0;
         // Accesses run back to back; each cycle checks the previous one.
         for (int i = 0; i <= 48; i++) begin
            @(negedge REF_CLK);
            if (i > 0) begin
               chk("target", ACC_TARGET, pe[3:0]);
               chk("addr_error", ADDR_ERROR, pe[4]);
               chk("fetch_error", FETCH_ERROR, pf);
            end
            pg = ($urandom_range(3) == 0) ? 4'($urandom) : 4'h0;
            case ($urandom_range(3))
               0: a = REG_FIELD_BASE + 16'($urandom_range(383));
               1: a = RAM_BASE + 16'($urandom_range(2047));
               2: a = 16'($urandom_range(32767));
               default: a = 16'($urandom);
            endcase
            if (i < 8 || i == 47) pg = 4'h0;
            if (i < 8) a = corner[i];
            f = ($urandom_range(1) == 1) && (a < REG_FIELD_BASE);
            if (i == 47) begin
               a = MODE_STATUS_ADDR;
               f = 1'b1;
            end
            ACC_VALID = (i < 48);
            ACC_PAGE = pg;
            ACC_ADDR = a;
            ACC_FETCH = f;
            pe = exp_acc(m, r == 0, pg, a);
            pf = f && (a >= REG_FIELD_BASE) && (pg == 4'h0);
         end
         if (r == 0) begin
            reg_wr(RAM_CONTROL_ADDR, 8'h00);
            @(negedge REF_CLK);
         end
      end
   endtask

   task automatic conclude();
      $display("Checked %0d values, %0d mismatches", samples_checked,
         mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(32'h5cfcef55));
      foreach (codes[k]) begin
         run_mode(codes[k]);
      end
      conclude();
   end

   // The whole sequence needs under a thousand cycles; this is generous.
   initial begin
      repeat (5000) @(posedge REF_CLK);
      mismatches++;
      conclude();
   end
endmodule // mms_mode_map_tb

// File: verilog/mms_mode_map.sv
// Behaviour
// - Strap pins latched at reset release, held
// - Codes 1,2,3,4,7 select matching modes
// - Modes 1,2: 64 kbyte, minimum CPU mode
// - Modes 3,4: 1 Mbyte, maximum CPU mode
// - ROM mapped in modes 2,4,7 only
// - Modes 2,4: vectors from on-chip ROM
// - Modes 1,3,7: vectors from outside ROM
// - Mode 7: no external bus, all GPIO
// - Modes 1,2: ports 1-2 ctrl,3 data,4-5 addr
// - Modes 3,4: ports 4,5,6 carry address
// - Mode 2: port 5 starts as input
// - Mode 4: ports 5,6 start as inputs
// - Modes 3,4: interrupt also saves code page
// - 64 kbyte pages; 16 in modes 3,4
// - Top 384 page-0 addresses are registers
// - RAM enable bit routes RAM range
// - Mode 7, RAM off: range gives address error
// - Mode status readable, writes ignored
// - Status bits 7,6 one; 5..3 zero
// - Status bits 2..0 are latched straps
`timescale 1ns/10ps
module mms_mode_map
   import mms_pkg::*;
#(
   parameter logic [15:0] ROM_LAST = mms_pkg::ROM_LAST_DEFAULT
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic [2:0] STRAP_PINS,
   input wire logic [3:0] ACC_PAGE,
   input wire logic [15:0] ACC_ADDR,
   input wire logic ACC_VALID,
   input wire logic ACC_FETCH,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic [2:0] LATCHED_STRAP_BITS,
   output logic MAX_MODE,
   output logic ROM_MAPPED,
   output logic VECTORS_IN_ROM,
   output logic EXT_BUS_EN,
   output logic PORT6_ADDR_EN,
   output logic PORT5_INIT_INPUT,
   output logic PORT6_INIT_INPUT,
   output logic SAVE_CODE_PAGE,
   output logic [3:0] PAGE_LAST,
   output logic RAM_ENABLE,
   output logic [3:0] ACC_TARGET,
   output logic ADDR_ERROR,
   output logic FETCH_ERROR
);
   import mms_pkg::*;

   // -------------------------------------------------------------------
   // Reset release and strap capture
   // -------------------------------------------------------------------
   logic rst_sync_n;
   logic [2:0] strap_sync;
   logic armed_reg;
   logic [2:0] strap_reg;

   mms_sync2 #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
      .clk(REF_CLK),
      .rst_n(RSTN),
      .d(1'b1),
      .q(rst_sync_n)
   );

   mms_sync2 #(.WIDTH(3), .INIT(STRAP_RESET)) u_strap_sync (
      .clk(REF_CLK),
      .rst_n(rst_sync_n),
      .d(STRAP_PINS),
      .q(strap_sync)
   );

   // The capture waits two edges so that both synchroniser stages hold
   // real pin values rather than their reset value; later pin changes
   // are ignored.
   logic [1:0] settle_reg;
   always_ff @(posedge REF_CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         settle_reg <= 2'h0;
         armed_reg <= 1'b1;
         strap_reg <= STRAP_RESET;
      end else begin
         settle_reg <= {settle_reg[0], 1'b1};
         if (armed_reg && settle_reg[1]) begin
            strap_reg <= strap_sync;
            armed_reg <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Mode decode
   // -------------------------------------------------------------------
   logic m_min_ext, m_max_ext, m_single, m_rom;
   always_comb begin
      m_min_ext = (strap_reg == MODE_1) || (strap_reg == MODE_2);
      m_max_ext = (strap_reg == MODE_3) || (strap_reg == MODE_4);
      m_single = (strap_reg == MODE_7);
      m_rom = (strap_reg == MODE_2) || (strap_reg == MODE_4) ||
              m_single;
   end

   logic ram_en_reg;
   always_ff @(posedge REF_CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         LATCHED_STRAP_BITS <= STRAP_RESET;
         MAX_MODE <= 1'b0;
         ROM_MAPPED <= 1'b0;
         VECTORS_IN_ROM <= 1'b0;
         EXT_BUS_EN <= 1'b0;
         PORT6_ADDR_EN <= 1'b0;
         PORT5_INIT_INPUT <= 1'b0;
         PORT6_INIT_INPUT <= 1'b0;
         SAVE_CODE_PAGE <= 1'b0;
         PAGE_LAST <= 4'h0;
         RAM_ENABLE <= RAM_ENABLE_RESET;
      end else begin
         LATCHED_STRAP_BITS <= strap_reg;
         MAX_MODE <= m_max_ext;
         ROM_MAPPED <= m_rom;
         VECTORS_IN_ROM <= (strap_reg == MODE_2) ||
                           (strap_reg == MODE_4);
         EXT_BUS_EN <= m_min_ext || m_max_ext;
         PORT6_ADDR_EN <= m_max_ext;
         PORT5_INIT_INPUT <= (strap_reg == MODE_2) ||
                             (strap_reg == MODE_4);
         PORT6_INIT_INPUT <= (strap_reg == MODE_4);
         SAVE_CODE_PAGE <= m_max_ext;
         PAGE_LAST <= m_max_ext ? PAGE_LAST_MAX : 4'h0;
         RAM_ENABLE <= ram_en_reg;
      end
   end

   // -------------------------------------------------------------------
   // Register field: RAM control and mode status
   // -------------------------------------------------------------------
   // Only the enable bit is stored; the other RAM control bits are not
   // implemented here and read back as their reset value.
   always_ff @(posedge REF_CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ram_en_reg <= RAM_ENABLE_RESET;
      end else if (REG_WR && REG_ADDR == RAM_CONTROL_ADDR) begin
         ram_en_reg <= REG_WDATA[RAM_ENABLE_BIT];
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            RAM_CONTROL_ADDR: REG_RDATA <= {ram_en_reg,
                                 RAM_CONTROL_RESET[6:0]};
            MODE_STATUS_ADDR: REG_RDATA <= {MODE_STATUS_FIXED,
                                 strap_reg};
            default: REG_RDATA <= 8'h00;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Access decode
   // -------------------------------------------------------------------
   // Decode is one cycle late so the outputs stay registered.
   logic [3:0] tgt;
   logic out_of_space, ram_range, err_next, ferr_next;
   always_comb begin
      ram_range = (ACC_ADDR >= RAM_BASE) && (ACC_ADDR <= RAM_LAST);
      out_of_space = m_max_ext ? 1'b0 : (ACC_PAGE != 4'h0);
      if (ACC_PAGE == 4'h0 && ACC_ADDR >= REG_FIELD_BASE) begin
         tgt = MMS_TGT_REG;
      end else if (ACC_PAGE == 4'h0 && ram_range && ram_en_reg) begin
         tgt = MMS_TGT_RAM;
      end else if (ACC_PAGE == 4'h0 && m_rom && ACC_ADDR <= ROM_LAST) begin
         tgt = MMS_TGT_ROM;
      end else begin
         tgt = MMS_TGT_EXT;
      end
      err_next = ACC_VALID && (out_of_space ||
                 (m_single && tgt == MMS_TGT_EXT));
      ferr_next = ACC_VALID && ACC_FETCH && tgt == MMS_TGT_REG;
   end

   always_ff @(posedge REF_CLK or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ACC_TARGET <= 4'h0;
         ADDR_ERROR <= 1'b0;
         FETCH_ERROR <= 1'b0;
      end else begin
         ACC_TARGET <= (ACC_VALID && !err_next) ? tgt : 4'h0;
         ADDR_ERROR <= err_next;
         FETCH_ERROR <= ferr_next;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   // Mode outputs are registered from the latched code, so they are
   // checked one edge after the code is seen; the code itself no longer
   // moves once capture is over.
   a_strap_hold: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg |=> $stable(strap_reg))
      else $error("Latched strap changed after capture.");
   a_status_fixed: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) REG_RD && REG_ADDR == MODE_STATUS_ADDR
      |=> REG_RDATA[7:3] == MODE_STATUS_FIXED &&
      REG_RDATA[2:0] == strap_reg)
      else $error("Mode status read value wrong.");
   a_status_ro: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) REG_WR && REG_ADDR == MODE_STATUS_ADDR
      |=> $stable(strap_reg) && $stable(ram_en_reg))
      else $error("Write to mode status changed state.");
   a_single_noext: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) m_single && ACC_VALID
      |=> ACC_TARGET != MMS_TGT_EXT)
      else $error("External cycle in single-chip mode.");
   a_ram_err: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) m_single && !ram_en_reg && ACC_VALID &&
      ACC_PAGE == 4'h0 && ram_range |=> ADDR_ERROR)
      else $error("Missing address error for disabled RAM.");
   a_regfield_first: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) ACC_VALID && ACC_PAGE == 4'h0 && !err_next &&
      ACC_ADDR >= REG_FIELD_BASE |=> ACC_TARGET == MMS_TGT_REG)
      else $error("Register field not decoded.");
   a_ram_route: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) ACC_VALID && !err_next && ACC_PAGE == 4'h0 &&
      ram_range |=> ACC_TARGET == ($past(ram_en_reg) ? MMS_TGT_RAM :
      (m_rom && $past(ACC_ADDR) <= ROM_LAST ? MMS_TGT_ROM : MMS_TGT_EXT)))
      else $error("RAM range routed wrongly.");
   a_min_page: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !m_max_ext && ACC_VALID && ACC_PAGE != 4'h0
      |=> ADDR_ERROR)
      else $error("Page above 0 accepted in minimum mode.");
   a_max_flags: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) ##1 m_max_ext && $stable(strap_reg)
      |=> MAX_MODE && SAVE_CODE_PAGE && PORT6_ADDR_EN
      && PAGE_LAST == PAGE_LAST_MAX)
      else $error("Maximum mode flags wrong.");
   a_vec_rom: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) $stable(strap_reg) && (strap_reg == MODE_2 ||
      strap_reg == MODE_4) |=> VECTORS_IN_ROM && ROM_MAPPED)
      else $error("Vectors not in ROM.");
   a_strap_shown: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg |=> LATCHED_STRAP_BITS == strap_reg)
      else $error("Latched strap output differs from capture.");
   a_min_flags: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg && (strap_reg == MODE_1 ||
      strap_reg == MODE_2) |=> !MAX_MODE && !SAVE_CODE_PAGE &&
      PAGE_LAST == 4'h0)
      else $error("Minimum mode flags wrong.");
   a_rom_map: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg |=> ROM_MAPPED == (strap_reg == MODE_2 ||
      strap_reg == MODE_4 || strap_reg == MODE_7))
      else $error("On-chip ROM mapping wrong for mode.");
   a_vec_ext: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg && (strap_reg == MODE_1 ||
      strap_reg == MODE_3 || strap_reg == MODE_7) |=> !VECTORS_IN_ROM)
      else $error("Vectors placed in ROM in an external mode.");
   a_single_pins: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg && strap_reg == MODE_7
      |=> !EXT_BUS_EN && !PORT6_ADDR_EN)
      else $error("Bus pins claimed in single-chip mode.");
   a_min_bus: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg && (strap_reg == MODE_1 ||
      strap_reg == MODE_2) |=> EXT_BUS_EN && !PORT6_ADDR_EN)
      else $error("Minimum mode bus ports wrong.");
   a_max_bus: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg && (strap_reg == MODE_3 ||
      strap_reg == MODE_4) |=> EXT_BUS_EN && PORT6_ADDR_EN)
      else $error("Maximum mode bus ports wrong.");
   a_port_init: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) !armed_reg |=> PORT5_INIT_INPUT ==
      (strap_reg == MODE_2 || strap_reg == MODE_4) &&
      PORT6_INIT_INPUT == (strap_reg == MODE_4))
      else $error("Port start-up direction flags wrong.");
   a_fetch_err: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) ACC_VALID && ACC_FETCH && ACC_PAGE == 4'h0 &&
      ACC_ADDR >= REG_FIELD_BASE |=> FETCH_ERROR)
      else $error("Fetch from register field not flagged.");
   a_rom_route: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) ACC_VALID && !err_next && ACC_PAGE == 4'h0 &&
      ACC_ADDR <= ROM_LAST && ACC_ADDR < RAM_BASE
      |=> ACC_TARGET == (ROM_MAPPED ? MMS_TGT_ROM : MMS_TGT_EXT))
      else $error("Low page 0 address routed wrongly.");
   a_page_max: assert property (@(posedge REF_CLK) disable iff
      (!rst_sync_n) m_max_ext && ACC_VALID && ACC_PAGE != 4'h0
      |=> !ADDR_ERROR && ACC_TARGET == MMS_TGT_EXT)
      else $error("Upper page refused in maximum mode.");

   c_mode7: cover property (@(posedge REF_CLK) !armed_reg && m_single);
   c_mode4: cover property (@(posedge REF_CLK)
      !armed_reg && strap_reg == MODE_4);
   c_ram_off: cover property (@(posedge REF_CLK) $fell(ram_en_reg));
   c_addr_err: cover property (@(posedge REF_CLK) ADDR_ERROR);
   c_fetch_err: cover property (@(posedge REF_CLK) FETCH_ERROR);
endmodule // mms_mode_map

// File: verilog/mms_pkg.sv
package mms_pkg;

   // -------------------------------------------------------------------
   // Operating modes
   // -------------------------------------------------------------------
   localparam logic [2:0] MODE_1 = 3'h1;
   localparam logic [2:0] MODE_2 = 3'h2;
   localparam logic [2:0] MODE_3 = 3'h3;
   localparam logic [2:0] MODE_4 = 3'h4;
   localparam logic [2:0] MODE_7 = 3'h7;

   // -------------------------------------------------------------------
   // Register offsets, fields and reset values
   // -------------------------------------------------------------------
   localparam logic [15:0] RAM_CONTROL_ADDR = 16'hff11;
   localparam logic [15:0] MODE_STATUS_ADDR = 16'hff12;
   localparam int RAM_ENABLE_BIT = 7;
   localparam logic RAM_ENABLE_RESET = 1'b1;
   localparam logic [7:0] RAM_CONTROL_RESET = 8'h80;
   localparam logic [4:0] MODE_STATUS_FIXED = 5'h18;
   localparam logic [2:0] STRAP_RESET = 3'h0;

   // -------------------------------------------------------------------
   // Page 0 map
   // -------------------------------------------------------------------
   localparam logic [15:0] REG_FIELD_BASE = 16'hfe80;
   localparam logic [15:0] RAM_BASE = 16'hf680;
   localparam logic [15:0] RAM_LAST = 16'hfe7f;
   localparam logic [15:0] ROM_LAST_DEFAULT = 16'h7fff;
   localparam logic [3:0] PAGE_LAST_MAX = 4'hf;
   localparam logic [15:0] DIR56_ADDR = 16'hfe88;

   // -------------------------------------------------------------------
   // Decode targets, one-hot
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      MMS_TGT_REG = 4'h1,
      MMS_TGT_RAM = 4'h2,
      MMS_TGT_ROM = 4'h4,
      MMS_TGT_EXT = 4'h8
   } mms_target_t;

endpackage

// File: verilog/mms_sync2.sv
`timescale 1ns/10ps
module mms_sync2 #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_reg <= INIT;
         q <= INIT;
      end else begin
         stage1_reg <= d;
         q <= stage1_reg;
      end
   end
endmodule // mms_sync2
